// ===== dv/slcd_host_model.sv
// Purpose: serial host model that writes the segment driver registers.
// Assumes: data line is open drain, resolved by the bench with a pull-up.
// Notes:   clock line is push-pull from the host, no stretching seen.
`timescale 1ns/1ps
`default_nettype none
module slcd_host_model #(
    parameter int QTR = 5
) (
    // clock
    input  wire logic clk_in,
    // bus lines
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // changes land just after an edge, quarter bit is QTR clocks
    task automatic wait_q(input int n);
        repeat (n * QTR) @(posedge clk_in);
        #2;
    endtask : wait_q

    // msb first; data moves only while clock is low
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low_out = ~b[i];
            wait_q(1);
            scl_out = 1'b1;
            wait_q(2);
            scl_out = 1'b0;
            wait_q(1);
        end
        sda_low_out = 1'b0;
        wait_q(1);
        scl_out = 1'b1;
        wait_q(1);
        ack = ~sda_line_in;
        wait_q(1);
        scl_out = 1'b0;
        wait_q(1);
    endtask : put_byte

    ////////////////////////////////////////////////////////////////////
    // start, n bytes from the top of bytes, stop
    task automatic xfer(input logic [31:0] bytes, input int n,
                        output logic [3:0] acks);
        logic a;
        acks        = 4'h0;
        sda_low_out = 1'b0;
        wait_q(1);
        sda_low_out = 1'b1;
        wait_q(1);
        scl_out = 1'b0;
        wait_q(1);
        for (int k = 0; k < n; k++) begin
            put_byte(bytes[31 - 8 * k -: 8], a);
            acks = {acks[2:0], a};
        end
        sda_low_out = 1'b1;
        wait_q(1);
        scl_out = 1'b1;
        wait_q(1);
        sda_low_out = 1'b0;
        wait_q(2);
    endtask : xfer
endmodule : slcd_host_model
`default_nettype wire

// ===== dv/slcd_tb.sv
// Purpose: self-checking bench for the static segment driver.
// Assumes: shortened oscillator, 20 MHz clock, device code 8'h10.
// Notes:   expected pins are rebuilt from the written bank values.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import slcd_pkg::*;
    localparam int  TICK        = 4;
    localparam int  HALF        = 2;
    localparam int  BP_HALF_CYC = TICK * HALF;
    logic        clk_in;
    logic        resetn_in;
    logic        ext_bp_clk_in;
    logic        scl;
    logic        host_low;
    logic        sda_out;
    logic        sda_oe_out;
    logic [13:0] seg_out;
    logic        dual_out;
    wire logic   sda_line;
    int          err_count;
    int          checked;
    logic [7:0]  exp_lo;
    logic [7:0]  exp_hi;
    logic [3:0]  acks;

    // pull-up: high unless some party pulls low
    assign sda_line = ~(host_low | (sda_oe_out & ~sda_out));

    slcd_top #(.CTRL_CODE(8'h10), .OSC_TICK_CYC(TICK),
               .BP_HALF_TICKS(HALF)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .ext_bp_clk_in(ext_bp_clk_in), .seg_out(seg_out),
        .dual_out(dual_out));

    slcd_host_model #(.QTR(5)) host (
        .clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl),
        .sda_low_out(host_low));

    ////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : tick

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_ack(input logic [3:0] got, input logic [3:0] exp);
        cmp({12'h000, got}, {12'h000, exp});
    endtask : cmp_ack

    task automatic chk_pins(input logic bp);
        logic [14:0] exp;
        exp[13:0] = {exp_hi[6:0], exp_lo[6:0]} ^ {14{bp}};
        exp[14]   = exp_lo[SRC_SEL_BIT] ? bp : (exp_hi[SEG15_BIT] ^ bp);
        cmp({1'b0, dual_out, seg_out}, {1'b0, exp});
    endtask : chk_pins

    task automatic ext_chk(input logic v);
        ext_bp_clk_in = v;
        tick(5);
        chk_pins(v);
    endtask : ext_chk

    task automatic wr(input logic [7:0] c, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] exp_ack);
        host.xfer({c, a, d, 8'h00}, 3, acks);
        cmp_ack(acks, exp_ack);
    endtask : wr

    // half period count of the internal backplane on the dual pin
    task automatic osc_chk();
        int n;
        n = 0;
        while (dual_out !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        while (dual_out !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk_pins(1'b1);
        n = 0;
        while (dual_out === 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        cmp(16'(n), 16'(BP_HALF_CYC));
        chk_pins(1'b0);
    endtask : osc_chk

    task automatic report_and_stop();
        $display("mismatches=%0d comparisons=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // generous: whole sequence needs about 5k clocks
    initial begin
        repeat (60000) @(posedge clk_in);
        err_count++;
        report_and_stop();
    end

    initial begin
        resetn_in     = 1'b0;
        ext_bp_clk_in = 1'b0;
        err_count     = 0;
        checked       = 0;
        exp_lo        = LOW_RESET;
        exp_hi        = HIGH_RESET;
        tick(20);
        resetn_in = 1'b1;
        tick(5);
        ext_chk(1'b0);
        ext_chk(1'b1);
        wr(8'h10, WADDR_LOW, 8'h55, 4'b0111);
        exp_lo = 8'h55;
        ext_chk(1'b0);
        ext_chk(1'b1);
        wr(8'h10, WADDR_HIGH, 8'hb3, 4'b0111);
        exp_hi = 8'hb3;
        ext_chk(1'b0);
        ext_chk(1'b1);
        // other device code, read request, unknown word address
        wr(8'h00, WADDR_LOW, 8'hff, 4'b0000);
        wr(8'h11, WADDR_LOW, 8'hff, 4'b0000);
        wr(8'h10, 8'h33, 8'hff, 4'b0100);
        ext_chk(1'b0);
        host.xfer({8'h10, WADDR_HIGH, 8'h0f, 8'hf0}, 4, acks);
        cmp_ack(acks, 4'b1110);
        exp_hi = 8'h0f;
        ext_chk(1'b1);
        wr(8'h10, WADDR_LOW, 8'h81, 4'b0111);
        exp_lo        = 8'h81;
        ext_bp_clk_in = 1'b0;
        osc_chk();
        ext_bp_clk_in = 1'b1;
        osc_chk();
        wr(8'h10, WADDR_LOW, 8'h01, 4'b0111);
        exp_lo = 8'h01;
        for (int i = 0; i < 3; i++) begin
            tick(2 * BP_HALF_CYC);
            chk_pins(1'b1);
        end
        ext_chk(1'b0);
        // second reset in mid-run brings back the initial banks
        resetn_in = 1'b0;
        tick(3);
        cmp({1'b0, dual_out, seg_out}, 16'h0000);
        resetn_in = 1'b1;
        exp_lo    = LOW_RESET;
        exp_hi    = HIGH_RESET;
        ext_chk(1'b1);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

// ===== rtl/slcd_pkg.sv
// Purpose: shared constants and types plus the serial register port
//          of the static segment driver.
// Assumes: single 20 MHz clock, pins are asynchronous to it.
// Notes:   the serial port only accepts writes.
`timescale 1ns/1ps
`default_nettype none
package slcd_pkg;
    localparam int          CLK_HZ            = 20_000_000;
    localparam int          OSC_HZ            = 25_000;
    localparam int          OSC_PREDIV        = 8;
    localparam int          OSC_POSTDIV       = 64;
    localparam int          OSC_TICK_CYC_DEF  = CLK_HZ / OSC_HZ;
    localparam int          BP_HALF_TICKS_DEF = OSC_PREDIV * OSC_POSTDIV / 2;
    localparam logic [7:0]  WADDR_LOW         = 8'hf4;
    localparam logic [7:0]  WADDR_HIGH        = 8'hd0;
    localparam logic [7:0]  LOW_RESET         = 8'h00;
    localparam logic [7:0]  HIGH_RESET        = 8'h00;
    localparam logic [7:0]  CTRL_CODE_DEF     = 8'h00;
    localparam int          SRC_SEL_BIT       = 7;
    localparam int          SEG15_BIT         = 7;
    localparam int          BANK_SEGS         = 7;
    localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;

    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic [7:0] data;
    } slcd_wr_type;
endpackage : slcd_pkg

module slcd_i2c_slave
    import slcd_pkg::*;
#(
    parameter logic [7:0] CTRL_CODE = CTRL_CODE_DEF
) (
    // clock and reset
    input  wire logic  clk_in,
    input  wire logic  resetn_in,
    // serial pins
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe_out,
    // register write strobe
    output slcd_wr_type wr_out
);
    typedef enum logic [6:0] {
        I_IDLE  = 7'b0000001,
        I_ADDR  = 7'b0000010,
        I_ACK_A = 7'b0000100,
        I_WORD  = 7'b0001000,
        I_ACK_W = 7'b0010000,
        I_DATA  = 7'b0100000,
        I_ACK_D = 7'b1000000
    } slcd_i2c_st_type;

    logic            scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic            scl_rise, scl_fall, start_seen, stop_seen;
    slcd_i2c_st_type state, next_state;
    logic [3:0]      bit_cnt, next_bit_cnt;
    logic [7:0]      shreg, next_shreg;
    logic            sel_high, next_sel_high;
    logic            written, next_written;
    logic            next_oe;
    slcd_wr_type     next_wr;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, third stage only for edge detection
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    assign scl_rise   = scl_s2 & ~scl_d;
    assign scl_fall   = ~scl_s2 & scl_d;
    assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_seen  = scl_s2 & scl_d & ~sda_d & sda_s2;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_sel_high = sel_high;
        next_written  = written;
        next_oe       = sda_oe_out;
        next_wr       = '0;
        if (stop_seen) begin
            next_state = I_IDLE;
            next_oe    = 1'b0;
        end else if (start_seen) begin
            next_state   = I_ADDR;
            next_bit_cnt = 4'h0;
            next_oe      = 1'b0;
            next_written = 1'b0;
        end else begin
            case (state)
                I_ADDR, I_WORD, I_DATA: begin
                    if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
                        next_shreg   = {shreg[6:0], sda_s2};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        next_state = I_IDLE;
                        if (state == I_ADDR) begin
                            // foreign codes and reads get no ack
                            if (shreg[7:1] == CTRL_CODE[7:1]
                                    && !shreg[0]) begin
                                next_state = I_ACK_A;
                                next_oe    = 1'b1;
                            end
                        end else if (state == I_WORD) begin
                            if (shreg == WADDR_LOW
                                    || shreg == WADDR_HIGH) begin
                                next_state    = I_ACK_W;
                                next_oe       = 1'b1;
                                next_sel_high = (shreg == WADDR_HIGH);
                            end
                        end else if (!written) begin
                            // one data byte per transfer
                            next_wr.wr_low  = ~sel_high;
                            next_wr.wr_high = sel_high;
                            next_wr.data    = shreg;
                            next_written    = 1'b1;
                            next_state      = I_ACK_D;
                            next_oe         = 1'b1;
                        end
                    end
                end
                I_ACK_A, I_ACK_W, I_ACK_D: begin
                    if (scl_fall) begin
                        next_oe      = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_state   = (state == I_ACK_A) ? I_WORD : I_DATA;
                    end
                end
                default: begin
                    next_state = I_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state      <= I_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            sel_high   <= 1'b0;
            written    <= 1'b0;
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b0;
            wr_out     <= '0;
        end else begin
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            shreg      <= next_shreg;
            sel_high   <= next_sel_high;
            written    <= next_written;
            sda_oe_out <= next_oe;
            sda_out    <= 1'b0;
            wr_out     <= next_wr;
        end
    end
endmodule : slcd_i2c_slave
`default_nettype wire

// ===== rtl/slcd_top.sv
// Purpose: static segment driver, fourteen segment pins plus one pin
//          that is backplane output or segment fifteen.
// Assumes: 20 MHz clk_in; external backplane and serial pins async.
// Notes:   outputs are registered, one cycle behind the backplane.
`timescale 1ns/1ps
`default_nettype none
module slcd_top
    import slcd_pkg::*;
#(
    parameter logic [7:0] CTRL_CODE     = CTRL_CODE_DEF,
    parameter logic [7:0] LOW_INIT      = LOW_RESET,
    parameter logic [7:0] HIGH_INIT     = HIGH_RESET,
    parameter int         OSC_TICK_CYC  = OSC_TICK_CYC_DEF,
    parameter int         BP_HALF_TICKS = BP_HALF_TICKS_DEF
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    // backplane and segments
    input  wire logic        ext_bp_clk_in,
    output logic [13:0]      seg_out,
    output logic             dual_out
);
    localparam int OSC_W  = $clog2(OSC_TICK_CYC);
    localparam int HALF_W = (BP_HALF_TICKS > 1) ? $clog2(BP_HALF_TICKS) : 1;

    generate
        if (OSC_TICK_CYC < 2 || BP_HALF_TICKS < 1) begin : g_bad_param
            $error("slcd_top: divider parameters out of range");
        end
    endgenerate

    typedef enum logic [0:0] {
        SM_STATE0 = 1'b1
    } slcd_sm_type;

    slcd_wr_type      wr;
    logic [7:0]       ctrl_low, next_ctrl_low;
    logic [7:0]       ctrl_high, next_ctrl_high;
    slcd_sm_type      sm_state, next_sm_state;
    logic             por_done;
    logic             ext_s1, ext_s2;
    logic             backplane_src_select;
    logic             osc_gate_nand;
    logic [OSC_W-1:0] osc_cnt, next_osc_cnt;
    logic [HALF_W-1:0] half_cnt, next_half_cnt;
    logic             osc_tick;
    logic             bp_int, next_bp_int;
    logic             backplane_clk;
    logic [13:0]      next_seg;
    logic             next_dual;

    ////////////////////////////////////////////////////////////////////////
    slcd_i2c_slave #(
        .CTRL_CODE (CTRL_CODE)
    ) u_i2c (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_out    (sda_out),
        .sda_oe_out (sda_oe_out),
        .wr_out     (wr)
    );

    ////////////////////////////////////////////////////////////////////////
    // control banks loaded from the write strobes, plus a one-state machine
    always_comb begin
        next_ctrl_low  = wr.wr_low  ? wr.data : ctrl_low;
        next_ctrl_high = wr.wr_high ? wr.data : ctrl_high;
        case (sm_state)
            SM_STATE0: next_sm_state = SM_STATE0;
            default:   next_sm_state = SM_STATE0;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_low  <= LOW_INIT;
            ctrl_high <= HIGH_INIT;
            sm_state  <= SM_STATE0;
            por_done  <= 1'b0;
            ext_s1    <= 1'b0;
            ext_s2    <= 1'b0;
        end else begin
            ctrl_low  <= next_ctrl_low;
            ctrl_high <= next_ctrl_high;
            sm_state  <= next_sm_state;
            por_done  <= 1'b1;
            ext_s1    <= ext_bp_clk_in;
            ext_s2    <= ext_s1;
        end
    end

    assign backplane_src_select = ctrl_low[SRC_SEL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // oscillator model: held in reset while powered down, so it always
    // restarts with a full first half period
    assign osc_gate_nand = ~(backplane_src_select & por_done);
    assign osc_tick = (osc_cnt == OSC_W'(OSC_TICK_CYC - 1));

    always_comb begin
        next_osc_cnt  = osc_cnt;
        next_half_cnt = half_cnt;
        next_bp_int   = bp_int;
        if (osc_gate_nand) begin
            next_osc_cnt  = '0;
            next_half_cnt = '0;
            next_bp_int   = 1'b0;
        end else if (osc_tick) begin
            next_osc_cnt = '0;
            if (half_cnt == HALF_W'(BP_HALF_TICKS - 1)) begin
                next_half_cnt = '0;
                next_bp_int   = ~bp_int;
            end else begin
                next_half_cnt = half_cnt + 1'b1;
            end
        end else begin
            next_osc_cnt = osc_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            osc_cnt  <= '0;
            half_cnt <= '0;
            bp_int   <= 1'b0;
        end else begin
            osc_cnt  <= next_osc_cnt;
            half_cnt <= next_half_cnt;
            bp_int   <= next_bp_int;
        end
    end

    // clock_source_mux
    assign backplane_clk = backplane_src_select ? bp_int : ext_s2;

    ////////////////////////////////////////////////////////////////////////
    // segment drivers: high bit inverts the backplane (dark)
    always_comb begin
        next_seg[BANK_SEGS-1:0] = ctrl_low[BANK_SEGS-1:0]
                                ^ {BANK_SEGS{backplane_clk}};
        next_seg[13:BANK_SEGS]  = ctrl_high[BANK_SEGS-1:0]
                                ^ {BANK_SEGS{backplane_clk}};
        if (backplane_src_select) begin
            next_dual = bp_int;
        end else begin
            next_dual = ctrl_high[SEG15_BIT] ^ backplane_clk;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seg_out  <= 14'h0000;
            dual_out <= 1'b0;
        end else begin
            seg_out  <= next_seg;
            dual_out <= next_dual;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_low_seg_xor: assert property (por_done |-> seg_out[6:0] ==
        $past(ctrl_low[6:0] ^ {7{backplane_clk}}))
        else $error("low segment outputs wrong");
    a_high_seg_xor: assert property (por_done |-> seg_out[13:7] ==
        $past(ctrl_high[6:0] ^ {7{backplane_clk}}))
        else $error("high segment outputs wrong");
    a_dark_inverts: assert property (
        por_done && ctrl_low[0] |=> seg_out[0] == !$past(backplane_clk))
        else $error("dark segment not inverted");
    a_clear_follows: assert property (
        por_done && !ctrl_high[0] |=> seg_out[7] == $past(backplane_clk))
        else $error("clear segment not in phase");
    a_static_state: assert property (sm_state == SM_STATE0)
        else $error("static machine left its state");
    a_osc_gated: assert property (osc_gate_nand |=>
        osc_cnt == '0 && !bp_int)
        else $error("oscillator ran while gated");
    a_bp_half_period: assert property (
        $changed(bp_int) && !$past(osc_gate_nand) |-> $past(osc_tick)
        && $past(half_cnt) == HALF_W'(BP_HALF_TICKS - 1))
        else $error("backplane toggled off its divide point");
    // external path checked against the pin two edges back, not the mux
    a_src_mux: assert property (
        por_done && $past(por_done) |-> backplane_clk ==
        (backplane_src_select ? bp_int : $past(ext_bp_clk_in, 2)))
        else $error("backplane source wrong");
    a_dual_bp_out: assert property (
        por_done && backplane_src_select |=> dual_out == $past(bp_int))
        else $error("dual pin not backplane output");
    a_dual_seg15: assert property (por_done && !backplane_src_select
        |=> dual_out == $past(ctrl_high[7] ^ backplane_clk))
        else $error("dual pin not segment fifteen");
    a_src_write: assert property (wr.wr_low |=>
        backplane_src_select == $past(wr.data[SRC_SEL_BIT]))
        else $error("source select not written");

    c_write_low:  cover property (wr.wr_low);
    c_write_high: cover property (wr.wr_high);
    c_internal:   cover property ($rose(backplane_src_select));
    c_bp_toggle:  cover property (backplane_src_select ##1 $rose(bp_int));
endmodule : slcd_top
`default_nettype wire
